/* File: hdl/lmiu_pkg.sv */
// package: constants and types for the logical mask instruction unit
`default_nettype none
package lmiu_pkg;
  localparam int HALF_W = 16;
  localparam int WORD_W = 2 * HALF_W;
  localparam int ADDR_W = 16;
  localparam logic [8:0] OP_MASK_AND = 9'h004;
  localparam logic [8:0] OP_MASK_LOAD = 9'h018;
  localparam int CLK_PERIOD_NS = 10;
  localparam int EXEC_TIME_NS = 12000;
  localparam int EXEC_CYCLES = EXEC_TIME_NS / CLK_PERIOD_NS;
  localparam logic [WORD_W-1:0] WORD_RST = 32'h0000_0000;

  typedef struct packed {
    logic [HALF_W-1:0] left;
    logic [HALF_W-1:0] right;
  } lmiu_word_t;

  typedef struct packed {
    logic [8:0] opcode;
    logic [ADDR_W-1:0] addr;
  } lmiu_instr_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_READ = 2'b01,
    ST_EXEC = 2'b10,
    ST_DONE = 2'b11
  } lmiu_state_t;
endpackage
`default_nettype wire

/* File: hdl/lmiu_top.sv */
// design: logical mask instruction unit (mask-and and mask-load)
//
// Contract
// - every bit independent, no carries
// - logical add is bitwise or
// - logical multiply is bitwise and, unshifted
// - mask-and keeps bits where control word one
// - memory word into A, then multiply into accumulators
// - mask-and opcode, indexed address, twelve microseconds
// - mask-load copies memory word into B
// - mask-load opcode, indexed address, twelve microseconds
// - two sixteen-bit halves processed in parallel
`timescale 1ns/10ps
`default_nettype none
module lmiu_top
  import lmiu_pkg::*;
#(
  parameter int EXEC_CYC = EXEC_CYCLES
) (
  input wire logic CORE_CLK,
  input wire logic SRST,
  input wire logic START,
  input var lmiu_instr_t INSTR,
  input wire logic [ADDR_W-1:0] INDEX,
  input wire logic MEM_ACK,
  input var lmiu_word_t MEM_RDATA,
  input wire logic ACC_LOAD,
  input var lmiu_word_t ACC_IN,
  output logic MEM_REQ,
  output logic [ADDR_W-1:0] MEM_ADDR,
  output logic BUSY,
  output logic DONE,
  output logic ILLEGAL,
  output lmiu_word_t ACC,
  output lmiu_word_t BREG,
  output lmiu_word_t AREG
);

  // ****************************************
  // logical arithmetic
  // ****************************************
  // per-half functions keep each half its own element, no cross-half path
  function automatic lmiu_word_t lmul(input lmiu_word_t a, input lmiu_word_t b);
    lmiu_word_t r;
    r.left = a.left & b.left;
    r.right = a.right & b.right;
    return r;
  endfunction

  function automatic lmiu_word_t ladd(input lmiu_word_t a, input lmiu_word_t b);
    lmiu_word_t r;
    r.left = a.left | b.left;
    r.right = a.right | b.right;
    return r;
  endfunction

  // ****************************************
  // decode
  // ****************************************
  localparam logic [15:0] EXEC_LAST = 16'(EXEC_CYC - 1);

  lmiu_state_t state_q, state_d;
  logic is_and_q, is_and_d;
  logic [15:0] cnt_q, cnt_d;
  logic [ADDR_W-1:0] addr_q, addr_d;
  lmiu_word_t acc_q, acc_d, b_q, b_d, a_q, a_d;
  logic req_q, req_d, done_q, done_d, ill_q, ill_d;

  wire logic op_and = (INSTR.opcode == OP_MASK_AND);
  wire logic op_load = (INSTR.opcode == OP_MASK_LOAD);
  wire logic take = (state_q == ST_IDLE) && START;
  // indexed effective address from the address field of the instruction plus INDEX
  wire logic [ADDR_W-1:0] eff_addr = ADDR_W'(INSTR.addr + INDEX);
  wire logic cnt_end = (cnt_q == EXEC_LAST);
  // plain fetch into A: logical add of the word into a cleared A
  wire lmiu_word_t a_xfer = ladd(WORD_RST, MEM_RDATA);

  // ****************************************
  // sequencer
  // ****************************************
  always_comb begin
    state_d = state_q;
    is_and_d = is_and_q;
    // counts only in exec, so a slow fetch can never run it past its end value
    cnt_d = (state_q == ST_EXEC) ? 16'(cnt_q + 16'h0001) : 16'h0000;
    addr_d = addr_q;
    acc_d = acc_q;
    b_d = b_q;
    a_d = a_q;
    req_d = 1'b0;
    done_d = 1'b0;
    ill_d = 1'b0;
    case (state_q)
      ST_IDLE: begin
        if (ACC_LOAD) begin
          acc_d = ACC_IN;
        end
        if (take && (op_and || op_load)) begin
          is_and_d = op_and;
          addr_d = eff_addr;
          req_d = 1'b1;
          state_d = ST_READ;
        end else if (take) begin
          ill_d = 1'b1;
        end
      end
      ST_READ: begin
        req_d = ~MEM_ACK;
        if (MEM_ACK) begin
          // read only: memory is never written back
          if (is_and_q) begin
            a_d = a_xfer;
          end else begin
            b_d = MEM_RDATA;
          end
          state_d = ST_EXEC;
        end
      end
      ST_EXEC: begin
        if (cnt_end) begin
          if (is_and_q) begin
            acc_d = lmul(acc_q, a_q);
          end
          done_d = 1'b1;
          state_d = ST_DONE;
        end
      end
      ST_DONE: begin
        state_d = ST_IDLE;
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge CORE_CLK) begin
    if (SRST) begin
      state_q <= ST_IDLE;
      is_and_q <= 1'b0;
      cnt_q <= 16'h0000;
      addr_q <= '0;
      acc_q <= WORD_RST;
      b_q <= WORD_RST;
      a_q <= WORD_RST;
      req_q <= 1'b0;
      done_q <= 1'b0;
      ill_q <= 1'b0;
    end else begin
      state_q <= state_d;
      is_and_q <= is_and_d;
      cnt_q <= cnt_d;
      addr_q <= addr_d;
      acc_q <= acc_d;
      b_q <= b_d;
      a_q <= a_d;
      req_q <= req_d;
      done_q <= done_d;
      ill_q <= ill_d;
    end
  end

  logic busy_q;
  always_ff @(posedge CORE_CLK) begin
    if (SRST) begin
      busy_q <= 1'b0;
    end else begin
      busy_q <= (state_d != ST_IDLE) && (state_d != ST_DONE);
    end
  end

  assign MEM_REQ = req_q;
  assign MEM_ADDR = addr_q;
  assign BUSY = busy_q;
  assign DONE = done_q;
  assign ILLEGAL = ill_q;
  assign ACC = acc_q;
  assign BREG = b_q;
  assign AREG = a_q;

  // ****************************************
  // checks
  // ****************************************
  // a second, independent count of exec cycles for the timing checks
  logic [15:0] chk_exec_q;
  always_ff @(posedge CORE_CLK) begin
    if (SRST || state_q != ST_EXEC) begin
      chk_exec_q <= 16'h0000;
    end else begin
      chk_exec_q <= 16'(chk_exec_q + 16'h0001);
    end
  end

  a_and_result: assert property (@(posedge CORE_CLK) disable iff (SRST)
    (state_q == ST_EXEC && cnt_end && is_and_q) |=> (acc_q == ($past(acc_q) & $past(a_q))))
    else $error("mask-and result wrong");
  a_load_b: assert property (@(posedge CORE_CLK) disable iff (SRST)
    (state_q == ST_READ && MEM_ACK && !is_and_q) |=> (b_q == $past(MEM_RDATA)))
    else $error("mask-load did not copy word");
  a_and_keeps_b: assert property (@(posedge CORE_CLK) disable iff (SRST)
    (state_q != ST_IDLE && is_and_q) |=> $stable(b_q))
    else $error("mask-and changed B");
  a_load_keeps_acc: assert property (@(posedge CORE_CLK) disable iff (SRST)
    (state_q != ST_IDLE && !is_and_q) |=> $stable(acc_q))
    else $error("mask-load changed accumulator");
  a_a_fetch: assert property (@(posedge CORE_CLK) disable iff (SRST)
    (state_q == ST_READ && MEM_ACK && is_and_q) |=> (a_q == $past(MEM_RDATA)))
    else $error("control word not in A");
  a_exec_time: assert property (@(posedge CORE_CLK) disable iff (SRST)
    (state_q == ST_EXEC && chk_exec_q == EXEC_LAST) |=> (DONE && state_q == ST_DONE))
    else $error("execution did not end at its fixed length");
  a_exec_early: assert property (@(posedge CORE_CLK) disable iff (SRST)
    (state_q == ST_EXEC && chk_exec_q != EXEC_LAST) |=> (state_q == ST_EXEC && !DONE))
    else $error("execution ended early");
  a_done_count: assert property (@(posedge CORE_CLK) disable iff (SRST)
    $rose(DONE) |-> ($past(cnt_q) == EXEC_LAST))
    else $error("done at wrong count");
  a_addr_index: assert property (@(posedge CORE_CLK) disable iff (SRST)
    (take && (op_and || op_load)) |=> (MEM_ADDR == $past(eff_addr)) && MEM_REQ)
    else $error("indexed address wrong");
  a_half_indep: assert property (@(posedge CORE_CLK) disable iff (SRST)
    (state_q == ST_EXEC && cnt_end && is_and_q) |=>
      (acc_q.left == ($past(acc_q.left) & $past(a_q.left))))
    else $error("left half not independent");
  a_right_indep: assert property (@(posedge CORE_CLK) disable iff (SRST)
    (state_q == ST_EXEC && cnt_end && is_and_q) |=>
      (acc_q.right == ($past(acc_q.right) & $past(a_q.right))))
    else $error("right half not independent");
  a_done_pulse: assert property (@(posedge CORE_CLK) disable iff (SRST)
    DONE |=> !DONE)
    else $error("done held longer than one cycle");
  a_illegal_quiet: assert property (@(posedge CORE_CLK) disable iff (SRST)
    (take && !op_and && !op_load) |=> (ILLEGAL && !BUSY && !MEM_REQ))
    else $error("unknown opcode started a fetch");
  a_req_drop: assert property (@(posedge CORE_CLK) disable iff (SRST)
    (state_q == ST_READ && MEM_ACK) |=> !MEM_REQ)
    else $error("memory request held after answer");

endmodule
`default_nettype wire

/* File: tb/lmiu_mem.sv */
// core memory model: read-only, answers after a short or a long wait
`timescale 1ns/10ps
`default_nettype none
module lmiu_mem
  import lmiu_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic req,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic slow,
  output logic ack,
  output lmiu_word_t rdata
);
  logic [3:0] cnt_q;
  logic [15:0] f_q;
  // off-ack data moves every cycle so stale sampling shows up
  assign rdata = ack ? {addr ^ 16'h5a0f, ~addr} : {f_q, ~f_q};
  always_ff @(posedge clk) begin
    f_q <= rst ? 16'h0000 : f_q + 16'h0001;
    if (rst || !req || ack) begin
      cnt_q <= 4'h0;
      ack <= 1'b0;
    end else begin
      cnt_q <= cnt_q + 4'h1;
      ack <= (cnt_q == (slow ? 4'h6 : 4'h0));
    end
  end
endmodule
`default_nettype wire

/* File: tb/test_logical_mask_instruction_unit.sv */
// self-checking bench for the logical mask instruction unit
`timescale 1ns/10ps
`default_nettype none
module test_logical_mask_instruction_unit
  import lmiu_pkg::*;
;
  logic CORE_CLK, SRST, START, MEM_ACK, ACC_LOAD, MEM_REQ, BUSY, DONE, ILLEGAL, slow;
  lmiu_instr_t INSTR;
  logic [ADDR_W-1:0] INDEX, MEM_ADDR, ea;
  lmiu_word_t MEM_RDATA, ACC_IN, ACC, BREG, AREG;
  int fails = 0, cmp_count = 0, cyc = 0, n;
  localparam int TB_EXEC = 4;
  // memory answers 1 (fast) or 7 (slow) cycles after the request, word {ea ^ 5a0f, ~ea}
  typedef struct packed {
    logic [8:0] op;
    logic [15:0] a, x;
    logic [31:0] acc;
    logic s;
    logic [15:0] ea;
    logic [31:0] w, acc_x, b_x;
  } lmiu_row_t;
  // inputs, then expected address, memory word, accumulators and B registers
  lmiu_row_t rows [4] = '{
    '{OP_MASK_AND, 16'h0001, 16'h0000, 32'hffff_0f0f, 1'b0,
      16'h0001, 32'h5a0e_fffe, 32'h5a0e_0f0e, 32'h0000_0000},
    '{OP_MASK_AND, 16'hfff0, 16'h0020, 32'h1234_abcd, 1'b1,
      16'h0010, 32'h5a1f_ffef, 32'h1214_abcd, 32'h0000_0000},
    '{OP_MASK_LOAD, 16'h00ff, 16'h0001, 32'h5555_aaaa, 1'b1,
      16'h0100, 32'h5b0f_feff, 32'h5555_aaaa, 32'h5b0f_feff},
    '{OP_MASK_LOAD, 16'hffff, 16'h0000, 32'h0000_0000, 1'b0,
      16'hffff, 32'ha5f0_0000, 32'h0000_0000, 32'ha5f0_0000}};
  lmiu_top #(.EXEC_CYC(TB_EXEC)) lmiu_top_i (.CORE_CLK(CORE_CLK), .SRST(SRST), .START(START),
    .INSTR(INSTR), .INDEX(INDEX), .MEM_ACK(MEM_ACK), .MEM_RDATA(MEM_RDATA),
    .ACC_LOAD(ACC_LOAD), .ACC_IN(ACC_IN), .MEM_REQ(MEM_REQ), .MEM_ADDR(MEM_ADDR),
    .BUSY(BUSY), .DONE(DONE), .ILLEGAL(ILLEGAL), .ACC(ACC), .BREG(BREG), .AREG(AREG));
  lmiu_mem lmiu_mem_i (.clk(CORE_CLK), .rst(SRST), .req(MEM_REQ), .addr(MEM_ADDR),
    .slow(slow), .ack(MEM_ACK), .rdata(MEM_RDATA));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fails++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic end_sim();
    $display("compares=%0d mismatches=%0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // one instruction: take, then wait for the done or illegal pulse under a bound
  task automatic run(input logic [8:0] op, input logic [15:0] a, input logic [15:0] x);
    INSTR = '{opcode: op, addr: a};
    INDEX = x;
    START = 1'b1;
    @(posedge CORE_CLK) #1;
    START = 1'b0;
    n = 1;
    while (DONE !== 1'b1 && ILLEGAL !== 1'b1 && n < 60) begin
      if (MEM_REQ === 1'b1) ea = MEM_ADDR;
      @(posedge CORE_CLK) #1;
      n++;
    end
  endtask
  initial begin
    CORE_CLK = 1'b0;
    forever #5 CORE_CLK = ~CORE_CLK;
  end
  always @(posedge CORE_CLK) begin
    cyc++;
    if (cyc == 3000) begin
      fails++;
      end_sim();
    end
  end
  initial begin
    {SRST, START, ACC_LOAD, slow} = 4'b1000;
    INSTR = '0;
    INDEX = '0;
    ACC_IN = '0;
    repeat (12) @(posedge CORE_CLK);
    #1 SRST = 1'b0;
    chk(ACC, WORD_RST);
    chk(BREG, WORD_RST);
    chk(AREG, WORD_RST);
    chk(32'({BUSY, DONE, ILLEGAL, MEM_REQ}), 32'h0000_0000);
    foreach (rows[i]) begin
      // a start while done still stands is refused, so let it fall first
      @(posedge CORE_CLK) #1;
      chk(32'({BUSY, DONE}), 32'h0000_0000);
      ACC_IN = rows[i].acc;
      slow = rows[i].s;
      ACC_LOAD = 1'b1;
      @(posedge CORE_CLK) #1;
      ACC_LOAD = 1'b0;
      run(rows[i].op, rows[i].a, rows[i].x);
      chk(32'(ea), 32'(rows[i].ea));
      chk(n, rows[i].s ? 9 + TB_EXEC : 3 + TB_EXEC);
      if (rows[i].op == OP_MASK_AND) begin
        chk(AREG, rows[i].w);
        chk(ACC, rows[i].acc_x);
        chk(BREG, rows[i].b_x);
      end else begin
        chk(ACC, rows[i].acc_x);
        chk(BREG, rows[i].b_x);
      end
    end
    // unknown opcode: a lone pulse, no fetch, registers untouched
    @(posedge CORE_CLK) #1;
    ACC_IN = 32'h0f0f_f0f0;
    ACC_LOAD = 1'b1;
    @(posedge CORE_CLK) #1;
    ACC_LOAD = 1'b0;
    run(9'h1ff, 16'h0010, 16'h0000);
    chk(32'({ILLEGAL, DONE, BUSY, MEM_REQ}), 32'h0000_0008);
    chk(n, 1);
    chk(ACC, 32'h0f0f_f0f0);
    chk(BREG, rows[3].b_x);
    // second start refused while busy, then a reset in mid-execution
    @(posedge CORE_CLK) #1;
    slow = 1'b0;
    INSTR = '{opcode: OP_MASK_AND, addr: 16'h0001};
    START = 1'b1;
    @(posedge CORE_CLK) #1;
    INSTR = '{opcode: 9'h1ff, addr: 16'h0001};
    @(posedge CORE_CLK) #1;
    START = 1'b0;
    chk(32'({ILLEGAL, BUSY}), 32'h0000_0001);
    @(posedge CORE_CLK) #1;
    SRST = 1'b1;
    @(posedge CORE_CLK) #1;
    SRST = 1'b0;
    chk(ACC, WORD_RST);
    chk(BREG, WORD_RST);
    chk(AREG, WORD_RST);
    chk(32'({BUSY, DONE, ILLEGAL, MEM_REQ}), 32'h0000_0000);
    run(OP_MASK_LOAD, 16'h00ff, 16'h0001);
    chk(32'(ea), 32'(rows[2].ea));
    chk(n, 3 + TB_EXEC);
    chk(BREG, rows[2].b_x);
    chk(ACC, WORD_RST);
    @(posedge CORE_CLK) #1;
    end_sim();
  end
endmodule
`default_nettype wire
